// [hw/srsl_pkg.sv]
// package: constants for the service request and status byte logic
// assumes: single 250 MHz clock domain, all inputs already synchronous
`default_nettype none
package srsl_pkg;
   // status byte and mask bit positions
   localparam int BIT_OVF       = 0;
   localparam int BIT_ILL_OPT   = 0;
   localparam int BIT_ILL_CMD   = 1;
   localparam int BIT_NO_REMOTE = 2;
   localparam int BIT_DONE      = 3;
   localparam int BIT_BUSY      = 4;
   localparam int BIT_ERR_VIEW  = 5;
   localparam int BIT_SRQ       = 6;
   localparam int BIT_UNUSED    = 7;
   // fields of the mask value
   localparam logic [7:0] DATA_MASK_BITS = 8'h19;
   localparam logic [2:0] ERR_MASK_BITS  = 3'h7;
   localparam logic [7:0] ERR_BANK_WT    = 8'h20;
   // reset values
   localparam logic [7:0] RST_BYTE       = 8'h00;
   localparam logic [2:0] RST_ERR_MASK   = 3'h0;
   localparam logic [7:0] RST_DATA_MASK  = 8'h00;
   // request state
   typedef enum logic [1:0] {
      SRSL_IDLE = 2'b01,
      SRSL_PEND = 2'b10
   } srsl_state_t;
endpackage : srsl_pkg
`default_nettype wire

// [hw/srsl_flag.sv]
// sticky flags: set pulses win over a clear pulse in the same cycle
// assumes: set and clear come from logic on mclk
`default_nettype none
module srsl_flag #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] set,
   input  wire logic         clr,
   output logic      [W-1:0] flag
);
   logic [W-1:0] flag_r;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         flag_r <= '0;
      end
      else
      begin
         flag_r <= (clr ? '0 : flag_r) | set;
      end
   end

   assign flag = flag_r;
endmodule // srsl_flag
`default_nettype wire

// [hw/srsl_top.sv]
// service request generation and status byte for a bus-attached instrument
// assumes: command parser, poll logic and measurement core share mclk
//
// Contract
// - power-up or device clear/selected clear zero both masks
// - any enabled condition raises a request; several may be enabled
// - value with bit 5 clear loads data mask: bits 0, 3, 4
// - value with bit 5 set loads error mask: bits 0, 1, 2
// - value 32 alone clears all error enables
// - data-caused byte has bit 5 clear, cause bits 0/3/4 set
// - error-caused byte has bit 5 set and exactly one error bit
// - only the first error is recorded until the byte is read
// - a generated request sets bit 6 of the status byte
// - with no request pending the byte shows live status
// - busy-caused request shows only the busy data bit
// - byte frozen from request until controller reads it
// - request line held until the status byte is read
// - illegal option sets flag; cleared on status byte read
// - illegal command sets flag; cleared on status byte read
// - overflow flag set when input exceeds selected range
// - reading-done flag set when conversion finishes
// - busy shown while a prior command is still executing
// - command in local operation raises not-in-remote error
// - byte presented during the serial poll sequence
// - mask reported as sum of enabled bit weights
`default_nettype none
module srsl_top (
   input  wire logic       mclk,
   input  wire logic       resetn,
   input  wire logic       bus_clear,
   input  wire logic       mask_wr,
   input  wire logic [7:0] mask_val,
   input  wire logic       overflow_evt,
   input  wire logic       conv_done,
   input  wire logic       busy,
   input  wire logic       illegal_option_error,
   input  wire logic       illegal_command_error,
   input  wire logic       device_dependent_command,
   input  wire logic       remote,
   input  wire logic       poll_rd,
   output logic            srq,
   output logic [7:0]      status_byte,
   output logic [7:0]      mask_data_sum,
   output logic [7:0]      mask_err_sum
);
   logic [7:0]          data_mask_r;
   logic [2:0]          err_mask_r;
   srsl_pkg::srsl_state_t state_r;
   logic [7:0]          frozen_r;
   logic [7:0]          status_r;
   logic                srq_r;
   logic [7:0]          mask_data_r;
   logic [7:0]          mask_err_r;
   logic                busy_d_r;
   logic [2:0]          err_flag;
   logic [1:0]          data_flag;
   logic [2:0]          err_set;
   logic [1:0]          data_set;
   logic                busy_rise;
   logic [2:0]          err_hit;
   logic [2:0]          err_first;
   logic                data_hit;
   logic                req_fire;
   logic [7:0]          cause_byte;
   logic [7:0]          live_byte;
   logic [7:0]          byte_nxt;
   logic                read_now;

   // lowest-numbered error wins so one bit is reported
   function automatic logic [2:0] first_one(input logic [2:0] v);
      if (v[0])
         first_one = 3'b001;
      else if (v[1])
         first_one = 3'b010;
      else if (v[2])
         first_one = 3'b100;
      else
         first_one = 3'b000;
   endfunction

   assign read_now = poll_rd & (state_r == srsl_pkg::SRSL_PEND);

   // error and data events
   assign err_set[srsl_pkg::BIT_ILL_OPT]   = illegal_option_error;
   assign err_set[srsl_pkg::BIT_ILL_CMD]   = illegal_command_error;
   assign err_set[srsl_pkg::BIT_NO_REMOTE] = device_dependent_command & ~remote;
   assign data_set[0] = overflow_evt;
   assign data_set[1] = conv_done;

   srsl_flag #(.W(3)) u_err_flags (
      .mclk   (mclk),
      .resetn (resetn),
      .set    (err_set),
      .clr    (poll_rd),
      .flag   (err_flag)
   );

   srsl_flag #(.W(2)) u_data_flags (
      .mclk   (mclk),
      .resetn (resetn),
      .set    (data_set),
      .clr    (poll_rd),
      .flag   (data_flag)
   );

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         busy_d_r <= 1'b0;
      end
      else
      begin
         busy_d_r <= busy;
      end
   end

   assign busy_rise = busy & ~busy_d_r;

   // mask loading
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         data_mask_r <= srsl_pkg::RST_DATA_MASK;
         err_mask_r  <= srsl_pkg::RST_ERR_MASK;
      end
      else if (bus_clear)
      begin
         data_mask_r <= srsl_pkg::RST_DATA_MASK;
         err_mask_r  <= srsl_pkg::RST_ERR_MASK;
      end
      else if (mask_wr && !mask_val[srsl_pkg::BIT_ERR_VIEW])
      begin
         data_mask_r <= mask_val & srsl_pkg::DATA_MASK_BITS;
      end
      else if (mask_wr)
      begin
         err_mask_r <= mask_val[2:0] & srsl_pkg::ERR_MASK_BITS;
      end
   end

   // request causes
   assign err_hit  = err_set & err_mask_r;
   assign err_first = first_one(err_hit);
   assign data_hit = (overflow_evt & data_mask_r[srsl_pkg::BIT_OVF])
                   | (conv_done & data_mask_r[srsl_pkg::BIT_DONE])
                   | (busy_rise & data_mask_r[srsl_pkg::BIT_BUSY]);
   assign req_fire = (|err_hit) | data_hit;

   always_comb
   begin
      cause_byte = srsl_pkg::RST_BYTE;
      cause_byte[srsl_pkg::BIT_SRQ] = 1'b1;
      if (|err_hit)
      begin
         cause_byte[srsl_pkg::BIT_ERR_VIEW] = 1'b1;
         cause_byte[2:0] = err_first;
      end
      else if (busy_rise && data_mask_r[srsl_pkg::BIT_BUSY])
      begin
         cause_byte[srsl_pkg::BIT_BUSY] = 1'b1;
      end
      else
      begin
         cause_byte[srsl_pkg::BIT_OVF]  = overflow_evt & data_mask_r[srsl_pkg::BIT_OVF];
         cause_byte[srsl_pkg::BIT_DONE] = conv_done & data_mask_r[srsl_pkg::BIT_DONE];
      end
   end

   // live view: error view while any error flag stands
   always_comb
   begin
      live_byte = srsl_pkg::RST_BYTE;
      if (|err_flag)
      begin
         live_byte[srsl_pkg::BIT_ERR_VIEW] = 1'b1;
         live_byte[2:0] = err_flag;
      end
      else
      begin
         live_byte[srsl_pkg::BIT_OVF]  = data_flag[0];
         live_byte[srsl_pkg::BIT_DONE] = data_flag[1];
         live_byte[srsl_pkg::BIT_BUSY] = busy;
      end
   end

   // request state: a new cause in the read cycle wins
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r  <= srsl_pkg::SRSL_IDLE;
         frozen_r <= srsl_pkg::RST_BYTE;
      end
      else
      begin
         case (state_r)
            srsl_pkg::SRSL_IDLE:
            begin
               if (req_fire)
               begin
                  state_r  <= srsl_pkg::SRSL_PEND;
                  frozen_r <= cause_byte;
               end
            end
            srsl_pkg::SRSL_PEND:
            begin
               if (poll_rd && req_fire)
               begin
                  frozen_r <= cause_byte;
               end
               else if (poll_rd)
               begin
                  state_r <= srsl_pkg::SRSL_IDLE;
               end
            end
            default:
            begin
               state_r <= srsl_pkg::SRSL_IDLE;
            end
         endcase
      end
   end

   always_comb
   begin
      if (state_r == srsl_pkg::SRSL_PEND && !poll_rd)
         byte_nxt = frozen_r;
      else if (req_fire)
         byte_nxt = cause_byte;
      else
         byte_nxt = live_byte;
   end

   // outputs
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         status_r <= srsl_pkg::RST_BYTE;
         srq_r    <= 1'b0;
      end
      else
      begin
         status_r <= byte_nxt;
         srq_r    <= (state_r == srsl_pkg::SRSL_PEND && !poll_rd) || req_fire;
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         mask_data_r <= srsl_pkg::RST_DATA_MASK;
         mask_err_r  <= srsl_pkg::RST_BYTE;
      end
      else
      begin
         mask_data_r <= data_mask_r;
         mask_err_r  <= (|err_mask_r) ? (srsl_pkg::ERR_BANK_WT | {5'h00, err_mask_r})
                                      : srsl_pkg::RST_BYTE;
      end
   end

   assign srq           = srq_r;
   assign status_byte   = status_r;
   assign mask_data_sum = mask_data_r;
   assign mask_err_sum  = mask_err_r;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence s_fire_idle;
      req_fire && state_r == srsl_pkg::SRSL_IDLE;
   endsequence

   sequence s_held;
      (state_r == srsl_pkg::SRSL_PEND && !poll_rd && !req_fire);
   endsequence

   sequence s_read_clean;
      read_now && !req_fire;
   endsequence

   sequence s_idle_calm;
      state_r == srsl_pkg::SRSL_IDLE && !req_fire;
   endsequence

   // mask bank loading
   chk_clear_masks: assert property (bus_clear |=> data_mask_r == 8'h00 && err_mask_r == 3'h0)
      else $error("masks not cleared");
   chk_data_load: assert property (mask_wr && !bus_clear && !mask_val[5]
                                   |=> data_mask_r == ($past(mask_val) & 8'h19) && $stable(err_mask_r))
      else $error("data mask load wrong");
   chk_err_load: assert property (mask_wr && !bus_clear && mask_val[5]
                                  |=> err_mask_r == $past(mask_val[2:0]) && $stable(data_mask_r))
      else $error("error mask load wrong");

   // request raise and cause encoding
   chk_srq_raise: assert property (s_fire_idle |=> srq && status_byte[6] && state_r == srsl_pkg::SRSL_PEND)
      else $error("request not raised");
   chk_err_onehot: assert property (s_fire_idle ##0 (|err_hit)
                                    |=> status_byte[5] && $onehot(status_byte[2:0]) && !status_byte[7])
      else $error("error byte not one-hot");
   chk_err_prio: assert property (s_fire_idle ##0 err_hit[0]
                                  |=> status_byte[2:0] == 3'h1)
      else $error("error priority wrong");
   chk_busy_only: assert property (s_fire_idle ##0 (err_hit == 3'h0 && busy_rise && data_mask_r[4])
                                   |=> status_byte == 8'h50)
      else $error("busy byte wrong");
   chk_data_cause: assert property (s_fire_idle ##0 (err_hit == 3'h0 && !(busy_rise && data_mask_r[4]))
                                    |=> (status_byte & 8'ha6) == 8'h00 && (status_byte[0] || status_byte[3]))
      else $error("data cause byte wrong");

   // hold until read, then live status
   chk_frozen_hold: assert property (s_held ##1 s_held |=> $stable(status_byte) && srq)
      else $error("frozen byte changed");
   chk_first_kept: assert property (state_r == srsl_pkg::SRSL_PEND && !poll_rd
                                    |=> $stable(frozen_r) && state_r == srsl_pkg::SRSL_PEND)
      else $error("first cause not kept");
   chk_read_drop: assert property (s_read_clean |=> !srq && !status_byte[6])
      else $error("read did not release request");
   chk_idle_quiet: assert property (s_idle_calm |=> !srq && !status_byte[6])
      else $error("live byte shows a request");
   chk_busy_live: assert property (s_idle_calm |=> status_byte[5] || status_byte[4] == $past(busy))
      else $error("live busy bit wrong");

   // flags and reported sums
   chk_remote_err: assert property (device_dependent_command && !remote |=> err_flag[2])
      else $error("not-in-remote flag missing");
   chk_flags_clear: assert property (poll_rd && err_set == 3'h0 |=> err_flag == 3'h0)
      else $error("error flags not cleared");
   chk_sum_track: assert property (1'b1 |=> mask_data_sum == $past(data_mask_r))
      else $error("data mask sum lags");
   chk_err_sum: assert property (mask_err_sum[5] == (|mask_err_sum[2:0])
                                 && (mask_err_sum & 8'hd8) == 8'h00)
      else $error("error mask sum malformed");
   chk_bit7_zero: assert property (##1 !status_byte[7])
      else $error("bit 7 set");
endmodule // srsl_top
`default_nettype wire

// [testbench/srsl_ctrl_model.sv]
// bus controller model: serial poll that samples the status byte and acknowledges the read
// assumes: srsl_top runs on the same mclk and samples poll_rd on rising edges
`default_nettype none
module srsl_ctrl_model (
   input  wire logic       mclk,
   input  wire logic [7:0] status_byte,
   output var  logic       poll_rd
);
   timeunit 1ns;
   timeprecision 1ps;
   initial poll_rd = 1'b0;
   // byte is taken during the poll, then the read releases the request line
   task automatic poll(output logic [7:0] b);
      @(negedge mclk);
      b = status_byte;
      poll_rd = 1'b1;
      @(negedge mclk);
      poll_rd = 1'b0;
   endtask
endmodule // srsl_ctrl_model
`default_nettype wire

// [testbench/service_request_status_logic_tb_top.sv]
// testbench for srsl_top: masks, requests, frozen byte, live status, random mask writes
// assumes: srsl_ctrl_model performs the serial poll reads
`default_nettype none
module service_request_status_logic_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       mclk = 1'b0;
   logic       resetn = 1'b0;
   logic [5:0] ev = 6'h00;
   logic       mask_wr = 1'b0;
   logic [7:0] mask_val = 8'h00;
   logic       busy = 1'b0;
   logic       remote = 1'b1;
   logic       poll_rd, srq;
   logic [7:0] status_byte, mask_data_sum, mask_err_sum, b, v, ed, ee;
   int         num_errors = 0;
   int         samples_checked = 0;
   always #2 mclk = ~mclk;
   srsl_top srsl_top_i (.mclk(mclk), .resetn(resetn), .bus_clear(ev[5]), .mask_wr(mask_wr),
      .mask_val(mask_val), .overflow_evt(ev[0]), .conv_done(ev[1]), .busy(busy),
      .illegal_option_error(ev[2]), .illegal_command_error(ev[3]), .device_dependent_command(ev[4]),
      .remote(remote), .poll_rd(poll_rd), .srq(srq), .status_byte(status_byte),
      .mask_data_sum(mask_data_sum), .mask_err_sum(mask_err_sum));
   srsl_ctrl_model srsl_ctrl_model_i (.mclk(mclk), .status_byte(status_byte), .poll_rd(poll_rd));
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wrap_up;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic settle;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic wm(input logic [7:0] m);
      @(negedge mclk);
      mask_wr = 1'b1;
      mask_val = m;
      @(negedge mclk);
      mask_wr = 1'b0;
      settle();
   endtask
   task automatic pulse(input int i);
      @(negedge mclk);
      ev[i] = 1'b1;
      @(negedge mclk);
      ev = 6'h00;
      settle();
   endtask
   // bounded wait for the request line, then the frozen byte
   task automatic req(input logic [7:0] e);
      int n;
      n = 0;
      while (srq !== 1'b1 && n < 8)
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (srq !== 1'b1)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, srq, 1'b1);
         wrap_up();
      end
      else
      begin
         chk(status_byte, e);
      end
   endtask
   task automatic rd(input logic [7:0] e);
      srsl_ctrl_model_i.poll(b);
      chk(b, e);
      settle();
      chk({7'h00, srq}, 8'h00);
   endtask
   function automatic logic [7:0] exp_err(input logic [7:0] m);
      return (m[2:0] == 3'h0) ? 8'h00 : {5'h04, m[2:0]};
   endfunction
   initial
   begin
      v = 8'($urandom(14629));
      ed = 8'h00;
      ee = 8'h00;
      repeat (12) @(posedge mclk);
      @(negedge mclk);
      resetn = 1'b1;
      settle();
      chk(mask_data_sum | mask_err_sum, 8'h00);
      chk(status_byte, 8'h00);
      // every documented mask command, then random mask values
      for (int i = 0; i < 60; i++)
      begin
         v = (i < 40) ? 8'(i) : 8'($urandom);
         if (i >= 40 || v[5] || (v & 8'he6) == 8'h00)
         begin
            wm(v);
            if (v[5])
               ee = exp_err(v);
            else
               ed = v & 8'h19;
            chk(mask_data_sum, ed);
            chk(mask_err_sum, ee);
         end
      end
      wm(8'h19);
      wm(8'h27);
      pulse(3);
      req(8'h62);
      pulse(2);
      chk(status_byte, 8'h62);
      pulse(0);
      repeat (10) @(posedge mclk);
      #1;
      chk({srq, status_byte[6:0]}, 8'he2);
      rd(8'h62);
      chk(status_byte, 8'h00);
      @(negedge mclk);
      remote = 1'b0;
      pulse(4);
      req(8'h64);
      rd(8'h64);
      @(negedge mclk);
      remote = 1'b1;
      busy = 1'b1;
      req(8'h50);
      rd(8'h50);
      chk(status_byte, 8'h10);
      @(negedge mclk);
      busy = 1'b0;
      pulse(1);
      req(8'h48);
      rd(8'h48);
      // overflow cause, then a new cause landing in the read cycle
      pulse(0);
      req(8'h41);
      fork
         srsl_ctrl_model_i.poll(b);
         begin
            @(negedge mclk);
            ev[1] = 1'b1;
            @(negedge mclk);
            ev = 6'h00;
         end
      join
      chk(b, 8'h41);
      settle();
      chk({srq, status_byte[6:0]}, 8'hc8);
      rd(8'h48);
      // two errors at once: lowest error bit is reported alone
      @(negedge mclk);
      ev = 6'h0c;
      @(negedge mclk);
      ev = 6'h00;
      settle();
      req(8'h61);
      rd(8'h61);
      wm(8'h20);
      chk(mask_err_sum, 8'h00);
      pulse(2);
      chk({srq, status_byte[6:0]}, 8'h21);
      rd(8'h21);
      wm(8'h00);
      chk(mask_data_sum, 8'h00);
      pulse(0);
      chk({srq, status_byte[6:0]}, 8'h01);
      pulse(1);
      chk(status_byte, 8'h09);
      rd(8'h09);
      wm(8'h19);
      wm(8'h27);
      pulse(5);
      chk(mask_data_sum | mask_err_sum, 8'h00);
      wrap_up();
   end
endmodule // service_request_status_logic_tb_top
`default_nettype wire
